/* File: ltd_data_mem.sv */
`timescale 1ns/1ps
module ltd_data_mem #(
	parameter logic [11:0] PORT_ADDR = 12'hF81
) (
	input  wire logic        clk_sys_i, // Clock.
	input  wire logic [11:0] addr_i,    // Operand address.
	input  wire logic        rd_i,      // Read strobe.
	input  wire logic        we_i,      // Write strobe.
	input  wire logic [7:0]  wdata_i,   // Write data.
	output logic      [7:0]  rdata_o,   // Read data.
	output logic             is_port_o  // Port address flag.
);
	logic [7:0] ram [4096];
	logic [7:0] junk = 8'hA5;
	// Undriven read data carries a moving pattern, never a stale byte.
	assign rdata_o = rd_i ? ram[addr_i] : junk;
	// One address stands for a port register whose pins differ.
	assign is_port_o = (addr_i == PORT_ADDR);
	// Writes land on the clock edge; the filler pattern moves each cycle.
	always @(posedge clk_sys_i) begin
		junk <= junk + 8'h3B;
		if (we_i) begin
			ram[addr_i] <= wdata_i;
		end
	end
endmodule

/* File: ltd_literal_table_op_decoder.sv */
`timescale 1ns/1ps
// Summary of operation
// - add_literal_op adds literal to working_register, sets C, DC, Z, OV, N.
// - and_literal_op ANDs literal into working_register, sets only Z and N.
// - or_literal_op ORs literal into working_register, sets only Z and N.
// - load_pointer_literal_op: two words, 12-bit literal to chosen pointer.
// - load_bank_literal_op puts 4-bit literal into low bank-select bits.
// - load_work_literal_op loads literal into working_register, no flags.
// - multiply_literal_op gives unsigned product of literal and W, no flags.
// - return_with_literal_op returns, loads literal into W, two cycles.
// - subtract_from_literal_op computes literal minus W, sets all five flags.
// - xor_literal_op XORs literal into working_register, sets Z and N.
// - program_read_op takes two cycles, low bits pick pointer mode.
// - program_write_op takes two cycles, low bits pick pointer mode.
// - Read-modify-write of a port register uses live pin levels.
// - Writing back to first_timer_count clears its assigned prescaler.
// - A program counter change takes two cycles, second one a no-op.
// - A stray second word of a two-word instruction runs as a no-op.
// - add_work_to_file_op adds W to f, d picks destination, five flags.
// - Bank bit 0 picks access bank, 1 uses bank_select_register.
// - Bank bit 0, extended set, f at most 95 selects indexed mode.
module ltd_literal_table_op_decoder #(
	parameter logic [11:0] TIMER_ADDR = 12'hFFF
) (
	input  wire logic                 clk_sys_i,            // System clock.
	input  wire logic                 reset_i,              // Sync reset.
	input  wire logic [15:0]          instr_i,              // Fetched word.
	input  wire logic                 ext_set_i,            // Extended set.
	input  wire logic [7:0]           mem_rdata_i,          // Data read.
	input  wire logic                 addr_is_port_i,       // Port address.
	input  wire logic [7:0]           pin_level_i,          // Raw pins.
	input  wire logic                 prescaler_assigned_i, // To timer.
	output logic      [1:0]           phase_o,              // Quarter.
	output logic      [11:0]          mem_addr_o,           // Data address.
	output logic                      mem_indexed_o,        // Indexed mode.
	output logic                      mem_rd_o,             // Read strobe.
	output logic                      mem_we_o,             // Write strobe.
	output logic      [7:0]           mem_wdata_o,          // Write data.
	output logic      [7:0]           working_register_o,               // Working reg.
	output logic      [7:0]           bsr_o,                // Bank select.
	output ltd_pkg::ltd_status_t      status_o,             // Flags.
	output logic      [15:0]          prod_o,               // Product.
	output logic                      ptr_load_o,           // Pointer load.
	output logic      [1:0]           ptr_sel_o,            // Pointer pick.
	output logic      [11:0]          ptr_value_o,          // Pointer value.
	output logic                      tbl_req_o,            // Table access.
	output ltd_pkg::ltd_tbl_t         tbl_o,                // Table kind.
	output logic                      ret_o,                // Return pulse.
	output logic                      prescaler_clr_o,      // Clear pulse.
	output logic                      nop_cycle_o           // Forced no-op.
);

	ltd_pkg::ltd_state_t  state;
	ltd_pkg::ltd_state_t  next_state;
	logic [1:0]           q;
	logic [15:0]          ir;
	logic [7:0]           opnd;
	logic [7:0]           pin_s1;
	logic [7:0]           pin_s2;
	logic [5:0]           ptr_hi;
	ltd_pkg::ltd_status_t next_status;
	logic [7:0]           next_result;

	// The phase output is the quarter counter flop itself.
	assign phase_o = q;

	// Decode of the held word; only a fresh instruction cycle decodes.
	wire       exec     = (state == ltd_pkg::ST_EXEC);
	wire [7:0] lit      = ir[7:0];
	wire       dec_add  = exec && ir[15:8] == ltd_pkg::OPB_ADD_LIT;
	wire       dec_and  = exec && ir[15:8] == ltd_pkg::OPB_AND_LIT;
	wire       dec_or   = exec && ir[15:8] == ltd_pkg::OPB_OR_LIT;
	wire       dec_movl = exec && ir[15:8] == ltd_pkg::OPB_MOVE_LIT;
	wire       dec_mul  = exec && ir[15:8] == ltd_pkg::OPB_MUL_LIT;
	wire       dec_ret  = exec && ir[15:8] == ltd_pkg::OPB_RET_LIT;
	wire       dec_sub  = exec && ir[15:8] == ltd_pkg::OPB_SUB_LIT;
	wire       dec_xor  = exec && ir[15:8] == ltd_pkg::OPB_XOR_LIT;
	wire       dec_bank = exec && ir[15:4] == ltd_pkg::OPP_BANK_LIT;
	wire       dec_ptr1 = exec && ir[15:6] == ltd_pkg::OPP_PTR_W1;
	wire       dec_tbl  = exec && ir[15:3] == ltd_pkg::OPP_TABLE;
	wire       dec_addf = exec && ir[15:10] == ltd_pkg::OPP_ADD_FILE;
	wire       dest_f   = ir[ltd_pkg::FLD_DEST];
	wire       bank_bit = ir[ltd_pkg::FLD_BANK];

	// Operand address: access bank, banked, or indexed literal offset.
	wire        acc_low  = lit < ltd_pkg::ACC_SPLIT;
	wire        indexed  = !bank_bit && ext_set_i &&
	                       lit <= ltd_pkg::IDX_MAX;
	wire [3:0]  acc_bank = acc_low ? ltd_pkg::ACC_LO_BANK :
	                                 ltd_pkg::ACC_HI_BANK;
	wire [11:0] f_addr   = bank_bit ? {bsr_o[3:0], lit} :
	                                  {acc_bank, lit};

	// Adder and subtractor paths with nibble carries for the digit flag.
	wire [7:0]  add_b  = dec_addf ? opnd : lit;
	wire [8:0]  sum9   = {1'b0, working_register_o} + {1'b0, add_b};
	wire [4:0]  sum_lo = {1'b0, working_register_o[3:0]} + {1'b0, add_b[3:0]};
	wire [8:0]  dif9   = {1'b0, lit} + {1'b0, ~working_register_o} + 9'h001;
	wire [4:0]  dif_lo = {1'b0, lit[3:0]} + {1'b0, ~working_register_o[3:0]} + 5'h01;
	wire        add_ov = (working_register_o[7] == add_b[7]) && (sum9[7] != working_register_o[7]);
	wire        sub_ov = (lit[7] != working_register_o[7]) && (dif9[7] != lit[7]);
	wire        arith  = dec_add || dec_addf || dec_sub;
	wire        logic_op = dec_and || dec_or || dec_xor;

	// Result and flag selection for the process quarter.
	always_comb begin
		next_status = status_o;
		next_result = working_register_o;
		if (dec_add || dec_addf) begin
			next_result = sum9[7:0];
			next_status.c  = sum9[8];
			next_status.dc = sum_lo[4];
			next_status.ov = add_ov;
		end else if (dec_sub) begin
			next_result = dif9[7:0];
			next_status.c  = dif9[8];
			next_status.dc = dif_lo[4];
			next_status.ov = sub_ov;
		end else if (dec_and) begin
			next_result = working_register_o & lit;
		end else if (dec_or) begin
			next_result = working_register_o | lit;
		end else if (dec_xor) begin
			next_result = working_register_o ^ lit;
		end else if (dec_movl || dec_ret) begin
			next_result = lit;
		end
		if (arith || logic_op) begin
			next_status.z = (next_result == ltd_pkg::RST_BYTE);
			next_status.n = next_result[7];
		end
	end

	// Next sequencer state, taken at the end of each instruction cycle.
	always_comb begin
		case (state)
			ltd_pkg::ST_EXEC: begin
				if (dec_ret || dec_tbl) begin
					next_state = ltd_pkg::ST_NOP;
				end else if (dec_ptr1) begin
					next_state = ltd_pkg::ST_PTR2;
				end else begin
					next_state = ltd_pkg::ST_EXEC;
				end
			end
			default: next_state = ltd_pkg::ST_EXEC;
		endcase
	end

	// Quarter-phase counter, fetch and cycle sequencing.
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			q           <= ltd_pkg::Q_DECODE;
			ir          <= ltd_pkg::RST_WORD;
			state       <= ltd_pkg::ST_EXEC;
			nop_cycle_o <= 1'b0;
		end else begin
			q <= q + 2'h1;
			if (q == ltd_pkg::Q_WRITE) begin
				ir          <= instr_i;   // Unmatched words decode as no-op.
				state       <= next_state;
				nop_cycle_o <= (next_state == ltd_pkg::ST_NOP);
			end
		end
	end

	// Pin levels come from outside the clock domain.
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			pin_s1 <= ltd_pkg::RST_BYTE;
			pin_s2 <= ltd_pkg::RST_BYTE;
		end else begin
			pin_s1 <= pin_level_i;
			pin_s2 <= pin_s1;
		end
	end

	// Decode and read quarters: address out, operand captured.
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			mem_addr_o    <= 12'h000;
			mem_indexed_o <= 1'b0;
			mem_rd_o      <= 1'b0;
			opnd          <= ltd_pkg::RST_BYTE;
		end else begin
			if (q == ltd_pkg::Q_DECODE) begin
				mem_addr_o    <= f_addr;
				mem_indexed_o <= dec_addf && indexed;
				mem_rd_o      <= dec_addf;
			end
			if (q == ltd_pkg::Q_READ) begin
				mem_rd_o <= 1'b0;
				opnd     <= addr_is_port_i ? pin_s2 : mem_rdata_i;
			end
		end
	end

	// Process quarter raises the strobes; they fall at the write edge.
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			mem_we_o        <= 1'b0;
			mem_wdata_o     <= ltd_pkg::RST_BYTE;
			prescaler_clr_o <= 1'b0;
			ret_o           <= 1'b0;
			tbl_req_o       <= 1'b0;
			tbl_o           <= '0;
			ptr_load_o      <= 1'b0;
			ptr_sel_o       <= 2'h0;
			ptr_value_o     <= 12'h000;
			ptr_hi          <= 6'h00;
		end else if (q == ltd_pkg::Q_PROCESS) begin
			mem_we_o        <= dec_addf && dest_f;
			mem_wdata_o     <= next_result;
			prescaler_clr_o <= dec_addf && dest_f && prescaler_assigned_i &&
			                   mem_addr_o == TIMER_ADDR;
			ret_o           <= dec_ret;
			tbl_req_o       <= dec_tbl;
			tbl_o           <= {ir[ltd_pkg::FLD_TBL_WR], ir[1:0]};
			if (dec_ptr1) begin
				ptr_hi <= ir[5:0];
			end
			if (state == ltd_pkg::ST_PTR2) begin
				ptr_load_o  <= 1'b1;
				ptr_sel_o   <= ptr_hi[5:4];
				ptr_value_o <= {ptr_hi[3:0], ir[7:0]};
			end
		end else begin
			mem_we_o        <= 1'b0;
			prescaler_clr_o <= 1'b0;
			ret_o           <= 1'b0;
			tbl_req_o       <= 1'b0;
			ptr_load_o      <= 1'b0;
		end
	end

	// Write quarter commits working register, flags, bank and product.
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			working_register_o   <= ltd_pkg::RST_BYTE;
			bsr_o    <= ltd_pkg::RST_BYTE;
			status_o <= '0;
			prod_o   <= ltd_pkg::RST_WORD;
		end else if (q == ltd_pkg::Q_WRITE) begin
			status_o <= next_status;
			if (!(dec_addf && dest_f)) begin
				working_register_o <= next_result;
			end
			if (dec_bank) begin
				bsr_o[3:0] <= lit[3:0];
			end
			if (dec_mul) begin
				prod_o <= 16'(working_register_o) * 16'(lit);
			end
		end
	end

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);

	property p_phase;
		q == ltd_pkg::Q_WRITE |=> q == ltd_pkg::Q_DECODE ##1 q == ltd_pkg::Q_READ;
	endproperty
	a_phase: assert property (p_phase) else $error("phase order broken");

	property p_add_lit;
		(q == ltd_pkg::Q_PROCESS && dec_add) |-> ##2
			working_register_o == 8'($past(working_register_o, 2) + $past(ir[7:0], 2));
	endproperty
	a_add_lit: assert property (p_add_lit) else $error("add literal bad");

	property p_and_lit;
		(q == ltd_pkg::Q_PROCESS && dec_and) |-> ##2
			working_register_o == ($past(working_register_o, 2) & $past(ir[7:0], 2)) &&
			status_o.c == $past(status_o.c, 2);
	endproperty
	a_and_lit: assert property (p_and_lit) else $error("and literal bad");

	property p_sub_lit;
		(q == ltd_pkg::Q_PROCESS && dec_sub) |-> ##2
			working_register_o == 8'($past(ir[7:0], 2) - $past(working_register_o, 2)) &&
			status_o.c == ($past(ir[7:0], 2) >= $past(working_register_o, 2));
	endproperty
	a_sub_lit: assert property (p_sub_lit) else $error("sub literal bad");

	property p_move_lit;
		(q == ltd_pkg::Q_PROCESS && dec_movl) |-> ##2
			working_register_o == $past(ir[7:0], 2) && $stable(status_o);
	endproperty
	a_move_lit: assert property (p_move_lit) else $error("move literal bad");

	property p_mul_lit;
		(q == ltd_pkg::Q_PROCESS && dec_mul) |-> ##2
			prod_o == 16'($past(working_register_o, 2) * $past(ir[7:0], 2));
	endproperty
	a_mul_lit: assert property (p_mul_lit) else $error("multiply bad");

	property p_ret_lit;
		(q == ltd_pkg::Q_PROCESS && dec_ret) |-> ##1 ret_o
			##1 (nop_cycle_o && state == ltd_pkg::ST_NOP)[*4];
	endproperty
	a_ret_lit: assert property (p_ret_lit) else $error("return not 2 cycles");

	property p_table;
		(q == ltd_pkg::Q_PROCESS && dec_tbl) |=>
			tbl_req_o && tbl_o.mode == $past(ir[1:0]) ##1 nop_cycle_o;
	endproperty
	a_table: assert property (p_table) else $error("table request bad");

	property p_ptr;
		(q == ltd_pkg::Q_PROCESS && dec_ptr1) |-> ##5 ptr_load_o &&
			ptr_sel_o == $past(ir[5:4], 5) &&
			ptr_value_o[11:8] == $past(ir[3:0], 5);
	endproperty
	a_ptr: assert property (p_ptr) else $error("pointer load bad");

	property p_bank;
		(q == ltd_pkg::Q_PROCESS && dec_bank) |-> ##2
			bsr_o[3:0] == $past(ir[3:0], 2) && $stable(status_o);
	endproperty
	a_bank: assert property (p_bank) else $error("bank load bad");

	property p_addf_dest;
		(q == ltd_pkg::Q_PROCESS && dec_addf) |=>
			mem_we_o == $past(dest_f) ##1 ($past(dest_f, 2) ?
			working_register_o == $past(working_register_o) : working_register_o == $past(mem_wdata_o));
	endproperty
	a_addf_dest: assert property (p_addf_dest) else $error("add file bad");

endmodule

/* File: ltd_literal_table_op_decoder_tb.sv */
`timescale 1ns/1ps
module ltd_literal_table_op_decoder_tb;
	logic                 clk_sys_i, reset_i, ext_set_i, presc_i;
	logic [15:0]          instr_i;
	logic [7:0]           pin_level_i, rdata;
	logic                 is_port, idx_seen = 1'b0, rst_q = 1'b1;
	logic [1:0]           phase_o, ptr_sel_o, ph_prev;
	logic [11:0]          mem_addr_o, ptr_value_o;
	logic                 mem_indexed_o, mem_rd_o, mem_we_o, ptr_load_o;
	logic                 tbl_req_o, ret_o, prescaler_clr_o, nop_cycle_o;
	logic [7:0]           mem_wdata_o, working_register_o, bsr_o;
	logic [15:0]          prod_o;
	ltd_pkg::ltd_status_t status_o;
	ltd_pkg::ltd_tbl_t    tbl_o, tbl_last;
	int                   n_mismatch = 0, checked = 0, cyc = 0;
	int                   n_ptr = 0, n_tbl = 0, n_ret = 0, n_clr = 0;
	int                   n_nop = 0;

	ltd_literal_table_op_decoder dut (
		.clk_sys_i(clk_sys_i), .reset_i(reset_i), .instr_i(instr_i),
		.ext_set_i(ext_set_i), .mem_rdata_i(rdata),
		.addr_is_port_i(is_port), .pin_level_i(pin_level_i),
		.prescaler_assigned_i(presc_i), .phase_o(phase_o),
		.mem_addr_o(mem_addr_o), .mem_indexed_o(mem_indexed_o),
		.mem_rd_o(mem_rd_o), .mem_we_o(mem_we_o),
		.mem_wdata_o(mem_wdata_o), .working_register_o(working_register_o), .bsr_o(bsr_o),
		.status_o(status_o), .prod_o(prod_o), .ptr_load_o(ptr_load_o),
		.ptr_sel_o(ptr_sel_o), .ptr_value_o(ptr_value_o),
		.tbl_req_o(tbl_req_o), .tbl_o(tbl_o), .ret_o(ret_o),
		.prescaler_clr_o(prescaler_clr_o), .nop_cycle_o(nop_cycle_o));

	ltd_data_mem dm (
		.clk_sys_i(clk_sys_i), .addr_i(mem_addr_o), .rd_i(mem_rd_o),
		.we_i(mem_we_o), .wdata_i(mem_wdata_o), .rdata_o(rdata),
		.is_port_o(is_port));

	// Free-running clock of 4 ns.
	initial begin
		clk_sys_i = 1'b0;
		forever #2 clk_sys_i = ~clk_sys_i;
	end

	// Compares one value and reports a mismatch at once.
	task automatic chk(input string nm, input logic [15:0] exp, got);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// Checks the working register and the flags together.
	task automatic cw(input logic [7:0] w, input logic [4:0] s);
		chk("working_register", {8'h00, w}, {8'h00, working_register_o});
		chk("status", {11'h000, s}, {11'h000, status_o});
	endtask

	// Presents one word so it is sampled at the next phase-3 edge.
	task automatic issue(input logic [15:0] w);
		@(negedge clk_sys_i);
		while (phase_o !== 2'h2) @(negedge clk_sys_i);
		@(posedge clk_sys_i);
		instr_i <= w;
		@(posedge clk_sys_i);
		instr_i <= 16'h0000;
	endtask

	// Waits until the commit edge four clocks after sampling has passed.
	task automatic settle;
		repeat (4) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
	endtask

	task automatic run(input logic [15:0] w);
		issue(w);
		settle;
	endtask

	task automatic end_sim;
		$display("mismatches %0d checks %0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Counts pulses, records table kinds and watches the phase order.
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		rst_q <= reset_i;
		ph_prev <= phase_o;
		if (!reset_i) begin
			n_ptr <= n_ptr + ptr_load_o;
			n_tbl <= n_tbl + tbl_req_o;
			n_ret <= n_ret + ret_o;
			n_clr <= n_clr + prescaler_clr_o;
			n_nop <= n_nop + nop_cycle_o;
			if (tbl_req_o) tbl_last <= tbl_o;
			if (mem_rd_o && mem_indexed_o) idx_seen <= 1'b1;
		end
		if (!reset_i && !rst_q) begin
			chk("phase", {14'h0, ph_prev + 2'h1}, {14'h0, phase_o});
		end
		if (cyc == 20000) begin
			n_mismatch++;
			end_sim;
		end
	end

	// Main sequence of instruction tests.
	initial begin
		reset_i = 1'b1;
		instr_i = 16'h0000;
		ext_set_i = 1'b0;
		presc_i = 1'b0;
		pin_level_i = 8'h5A;
		dm.ram[12'hF80] = 8'hC2;
		dm.ram[12'h710] = 8'h30;
		dm.ram[12'hF81] = 8'hFF;
		dm.ram[12'hFFF] = 8'h00;
		dm.ram[12'h020] = 8'h11;
		repeat (10) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		@(negedge clk_sys_i);
		cw(8'h00, 5'h00);
		run(16'h0E10); cw(8'h10, 5'h00);
		run(16'h0F15); cw(8'h25, 5'h00);
		run(16'h0FDB); cw(8'h00, 5'h07);
		run(16'h0EF0); cw(8'hF0, 5'h07);
		run(16'h0B8F); cw(8'h80, 5'h13);
		run(16'h090F); cw(8'h8F, 5'h13);
		run(16'h0A8F); cw(8'h00, 5'h07);
		run(16'h0E05); run(16'h0803); cw(8'hFE, 5'h10);
		run(16'h0D03); cw(8'hFE, 5'h10);
		chk("prod", 16'h02FA, prod_o);
		run(16'h0107); cw(8'hFE, 5'h10);
		chk("bank", 16'h0007, {8'h00, bsr_o});
		$display("test literal done");
		issue(16'h0C42); issue(16'h0E99); settle;
		cw(8'h42, 5'h10);
		chk("ret", 16'h0001, n_ret[15:0]);
		chk("nop", 16'h0004, n_nop[15:0]);
		issue(16'hEE2A); issue(16'hF0BC); settle;
		chk("ptr_val", 16'h0ABC, {4'h0, ptr_value_o});
		chk("ptr_sel", 16'h0002, {14'h0, ptr_sel_o});
		chk("ptr_n", 16'h0001, n_ptr[15:0]);
		cw(8'h42, 5'h10);
		run(16'hF123); cw(8'h42, 5'h10);
		$display("test flow done");
		for (int i = 0; i < 8; i++) begin
			run(16'h0008 + 16'(i));
			chk("tbl", {13'h0, 3'(i)}, {13'h0, tbl_last});
		end
		chk("tbl_n", 16'h0008, n_tbl[15:0]);
		settle;
		chk("nop", 16'h0024, n_nop[15:0]);
		cw(8'h42, 5'h10);
		$display("test table done");
		run(16'h0E17); run(16'h2480); cw(8'hD9, 5'h10);
		run(16'h2710); cw(8'hD9, 5'h01);
		chk("file", 16'h0009, {8'h00, dm.ram[12'h710]});
		run(16'h0E00); run(16'h2481); cw(8'h5A, 5'h00);
		chk("idx", 16'h0000, {15'h0, idx_seen});
		chk("clr", 16'h0000, n_clr[15:0]);
		@(posedge clk_sys_i);
		ext_set_i <= 1'b1;
		presc_i <= 1'b1;
		run(16'h2420);
		chk("idx", 16'h0001, {15'h0, idx_seen});
		cw(8'h6B, 5'h00);
		run(16'h26FF);
		chk("clr", 16'h0001, n_clr[15:0]);
		chk("timer", 16'h006B, {8'h00, dm.ram[12'hFFF]});
		$display("test file done");
		end_sim;
	end
endmodule

/* File: ltd_pkg.sv */
package ltd_pkg;

	// Upper bytes of the literal group.
	localparam logic [7:0]  OPB_ADD_LIT  = 8'h0F;
	localparam logic [7:0]  OPB_AND_LIT  = 8'h0B;
	localparam logic [7:0]  OPB_OR_LIT   = 8'h09;
	localparam logic [7:0]  OPB_MOVE_LIT = 8'h0E;
	localparam logic [7:0]  OPB_MUL_LIT  = 8'h0D;
	localparam logic [7:0]  OPB_RET_LIT  = 8'h0C;
	localparam logic [7:0]  OPB_SUB_LIT  = 8'h08;
	localparam logic [7:0]  OPB_XOR_LIT  = 8'h0A;

	// Prefixes of 6 to 13 bits for the remaining words.
	localparam logic [11:0] OPP_BANK_LIT = 12'h010;
	localparam logic [9:0]  OPP_PTR_W1   = 10'h3B8;
	localparam logic [7:0]  OPP_PTR_W2   = 8'hF0;
	localparam logic [12:0] OPP_TABLE    = 13'h0001;
	localparam logic [5:0]  OPP_ADD_FILE = 6'h09;

	// Field positions inside the instruction word.
	localparam int          FLD_DEST     = 9;
	localparam int          FLD_BANK     = 8;
	localparam int          FLD_TBL_WR   = 2;

	// Data memory addressing.
	localparam logic [7:0]  ACC_SPLIT    = 8'h60;
	localparam logic [7:0]  IDX_MAX      = 8'h5F;
	localparam logic [3:0]  ACC_HI_BANK  = 4'hF;
	localparam logic [3:0]  ACC_LO_BANK  = 4'h0;

	// Quarter-phase sequencing of one instruction cycle.
	localparam logic [1:0]  Q_DECODE     = 2'h0;
	localparam logic [1:0]  Q_READ       = 2'h1;
	localparam logic [1:0]  Q_PROCESS    = 2'h2;
	localparam logic [1:0]  Q_WRITE      = 2'h3;

	// Reset values.
	localparam logic [7:0]  RST_BYTE     = 8'h00;
	localparam logic [15:0] RST_WORD     = 16'h0000;

	// Arithmetic flags.
	typedef struct packed {
		logic n;
		logic ov;
		logic z;
		logic dc;
		logic c;
	} ltd_status_t;

	// Program-memory transfer request: direction and pointer mode.
	typedef struct packed {
		logic       write;
		logic [1:0] mode;
	} ltd_tbl_t;

	typedef enum logic [1:0] {
		ST_EXEC = 2'b00,
		ST_NOP  = 2'b01,
		ST_PTR2 = 2'b10
	} ltd_state_t;

endpackage
